// *** design/atomic_decode.v ***
`timescale 1ns/1ns
`include "atomic_rmw_defines.vh"
module atomic_decode (
  input  wire [31:0] instr,
  input  wire        pair_en,
  input  wire [1:0]  overlap_mode,
  output reg         is_xor,
  output reg         is_pair,
  output reg         undef,
  output reg         nop,
  output reg         rt_unknown,
  output reg         acquire,
  output reg         release_ord,
  output reg         tag_checked,
  output reg  [7:0]  width_bits,
  output reg         dest_write
);
  wire [4:0] tgt  = instr[`F_TGT_HI:`F_TGT_LO];
  wire [4:0] tgt2 = instr[`F_SRC_HI:`F_SRC_LO];
  wire [4:0] base = instr[`F_BASE_HI:`F_BASE_LO];
  wire [1:0] sz   = instr[`F_SIZE_HI:`F_SIZE_LO];
  wire       a    = instr[`F_ACQ];
  wire       r    = instr[`F_REL];

  // Field decode and checks
  always @* begin
    is_xor      = ((instr & `XOR_MASK) == `XOR_MATCH) && (sz != 2'h1);
    is_pair     = (instr & `PAIR_MASK) == `PAIR_MATCH;
    undef       = !is_xor && !is_pair;
    nop         = 1'b0;
    rt_unknown  = 1'b0;
    acquire     = 1'b0;
    release_ord = r;
    tag_checked = base != `REG_31;
    width_bits  = `WIDTH_BASE << sz;
    dest_write  = 1'b0;
    if (is_xor) begin
      acquire    = a && (tgt != `REG_31);
      dest_write = tgt != `REG_31;
    end
    if (is_pair) begin
      width_bits = 8'h80;
      acquire    = a;
      dest_write = 1'b1;
      if (!pair_en)
        undef = 1'b1;
      else if (tgt == `REG_31 || tgt2 == `REG_31)
        undef = 1'b1;
      else if (tgt == tgt2) begin
        case (overlap_mode)
          `OVL_UNDEF: undef = 1'b1;
          `OVL_NOP:   nop = 1'b1;
          default:    rt_unknown = 1'b1;
        endcase
      end
    end
  end
endmodule // atomic_decode

// *** design/atomic_rmw_defines.vh ***
`ifndef ATOMIC_RMW_DEFINES_VH
`define ATOMIC_RMW_DEFINES_VH
// Instruction field positions
`define F_SIZE_HI      31
`define F_SIZE_LO      30
`define F_ACQ          23
`define F_REL          22
`define F_SRC_HI       20
`define F_SRC_LO       16
`define F_BASE_HI      9
`define F_BASE_LO      5
`define F_TGT_HI       4
`define F_TGT_LO       0
// Fixed opcode bits for matching
`define XOR_MASK       32'h3f20fc00
`define XOR_MATCH      32'h38202000
`define PAIR_MASK      32'hff20fc00
`define PAIR_MATCH     32'h19201000
// Size codes
`define SIZE_BYTE      2'h0
`define SIZE_WORD      2'h2
`define SIZE_DWORD     2'h3
`define WIDTH_BASE     8'h08
// Register number of zero register / stack pointer
`define REG_31         5'h1f
// Memory op codes
`define MOP_XOR        2'h1
`define MOP_BIC        2'h2
// Register map (Avalon word addresses)
`define A_INSTR        3'h0
`define A_CTRL         3'h1
`define A_STATUS       3'h2
`define A_MASK         3'h3
`define A_RESULT_LO    3'h4
`define A_RESULT_HI    3'h5
// Control bits
`define C_GO           0
`define C_PAIR_EN      1
`define C_BIG_END      2
`define C_OVERLAP_HI   4
`define C_OVERLAP_LO   3
// Overlap policies
`define OVL_UNKNOWN    2'h0
`define OVL_UNDEF      2'h1
`define OVL_NOP        2'h2
// Status bits
`define S_DONE         0
`define S_UNDEF        1
`define S_NOP          2
`define S_BITS         3
`endif

// *** design/atomic_xor_clear_rmw.v ***
`timescale 1ns/1ns
`include "atomic_rmw_defines.vh"
module atomic_xor_clear_rmw (
  input  wire         clk,
  input  wire         rst,
  // Avalon-MM slave
  input  wire [2:0]   avs_address,
  input  wire         avs_read,
  input  wire         avs_write,
  input  wire [31:0]  avs_writedata,
  output reg  [31:0]  avs_readdata,
  output wire         avs_waitrequest,
  output wire         irq,
  // Register file read ports
  output wire [4:0]   rf_rd_a_idx,
  output wire [4:0]   rf_rd_b_idx,
  output wire [4:0]   rf_rd_c_idx,
  input  wire [63:0]  rf_rd_a_data,
  input  wire [63:0]  rf_rd_b_data,
  input  wire [63:0]  rf_rd_c_data,
  input  wire [63:0]  sp_value,
  // Register file write ports
  output reg          rf_wr_en,
  output reg  [4:0]   rf_wr_idx,
  output reg  [63:0]  rf_wr_data,
  output reg          rf_wr2_en,
  output reg  [4:0]   rf_wr2_idx,
  output reg  [63:0]  rf_wr2_data,
  // Memory atomic request
  output reg          mem_req_valid,
  input  wire         mem_req_ready,
  output reg  [63:0]  mem_addr,
  output reg  [127:0] mem_operand,
  output reg  [7:0]   mem_width,
  output reg  [1:0]   mem_op,
  output reg          mem_acquire,
  output reg          mem_release,
  output reg          mem_tag_checked,
  output reg          mem_sp_align_check,
  input  wire         mem_resp_valid,
  input  wire [127:0] mem_resp_data
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_REQ  = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_WB   = 4'h8;

  reg  [3:0]   state_reg;
  reg  [31:0]  instr_reg;
  reg          pair_en_reg;
  reg          big_end_reg;
  reg  [1:0]   overlap_reg;
  reg  [2:0]   status_reg;
  reg  [2:0]   mask_reg;
  reg  [127:0] result_reg;
  reg          dest_reg;
  reg          unk_reg;
  reg          is_pair_reg;
  reg  [7:0]   width_reg;
  reg  [2:0]   ev_set;
  reg          start;

  wire         is_xor;
  wire         is_pair;
  wire         undef;
  wire         nop;
  wire         rt_unknown;
  wire         acquire;
  wire         release_ord;
  wire         tag_checked;
  wire [7:0]   width_bits;
  wire         dest_write;

  wire [4:0] tgt  = instr_reg[`F_TGT_HI:`F_TGT_LO];
  wire [4:0] src  = instr_reg[`F_SRC_HI:`F_SRC_LO];
  wire [4:0] base = instr_reg[`F_BASE_HI:`F_BASE_LO];

  assign rf_rd_a_idx     = tgt;
  assign rf_rd_b_idx     = src;
  assign rf_rd_c_idx     = base;
  assign avs_waitrequest = 1'b0;
  assign irq             = |(status_reg & mask_reg);

  atomic_decode u_dec (
    .instr        (instr_reg),
    .pair_en      (pair_en_reg),
    .overlap_mode (overlap_reg),
    .is_xor       (is_xor),
    .is_pair      (is_pair),
    .undef        (undef),
    .nop          (nop),
    .rt_unknown   (rt_unknown),
    .acquire      (acquire),
    .release_ord  (release_ord),
    .tag_checked  (tag_checked),
    .width_bits   (width_bits),
    .dest_write   (dest_write)
  );

  // Zero-extend a loaded value to its width
  function [63:0] zext;
    input [63:0] d;
    input [7:0]  w;
    begin
      case (w)
        8'h08:   zext = {56'h0, d[7:0]};
        8'h10:   zext = {48'h0, d[15:0]};
        8'h20:   zext = {32'h0, d[31:0]};
        default: zext = d;
      endcase
    end
  endfunction

  // Register reads
  always @* begin
    case (avs_address)
      `A_INSTR:     avs_readdata = instr_reg;
      `A_CTRL:      avs_readdata = {27'h0, overlap_reg, big_end_reg, pair_en_reg, state_reg != ST_IDLE};
      `A_STATUS:    avs_readdata = {29'h0, status_reg};
      `A_MASK:      avs_readdata = {29'h0, mask_reg};
      `A_RESULT_LO: avs_readdata = result_reg[31:0];
      `A_RESULT_HI: avs_readdata = result_reg[63:32];
      default:      avs_readdata = 32'h0;
    endcase
  end

  // Control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_reg   <= 32'h0;
      pair_en_reg <= 1'b1;
      big_end_reg <= 1'b0;
      overlap_reg <= `OVL_UNKNOWN;
      mask_reg    <= 3'h0;
      start       <= 1'b0;
    end else begin
      start <= 1'b0;
      if (avs_write) begin
        case (avs_address)
          `A_INSTR: instr_reg <= avs_writedata;
          `A_CTRL: begin
            pair_en_reg <= avs_writedata[`C_PAIR_EN];
            big_end_reg <= avs_writedata[`C_BIG_END];
            overlap_reg <= avs_writedata[`C_OVERLAP_HI:`C_OVERLAP_LO];
            start       <= avs_writedata[`C_GO] && state_reg == ST_IDLE;
          end
          `A_MASK: mask_reg <= avs_writedata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky status, set wins over read-clear
  always @(posedge clk or posedge rst) begin
    if (rst)
      status_reg <= 3'h0;
    else if (avs_read && avs_address == `A_STATUS)
      status_reg <= ev_set;
    else
      status_reg <= status_reg | ev_set;
  end

  // Execution sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg          <= ST_IDLE;
      mem_req_valid      <= 1'b0;
      mem_addr           <= 64'h0;
      mem_operand        <= 128'h0;
      mem_width          <= 8'h0;
      mem_op             <= 2'h0;
      mem_acquire        <= 1'b0;
      mem_release        <= 1'b0;
      mem_tag_checked    <= 1'b0;
      mem_sp_align_check <= 1'b0;
      rf_wr_en           <= 1'b0;
      rf_wr_idx          <= 5'h0;
      rf_wr_data         <= 64'h0;
      rf_wr2_en          <= 1'b0;
      rf_wr2_idx         <= 5'h0;
      rf_wr2_data        <= 64'h0;
      result_reg         <= 128'h0;
      dest_reg           <= 1'b0;
      unk_reg            <= 1'b0;
      is_pair_reg        <= 1'b0;
      width_reg          <= 8'h0;
      ev_set             <= 3'h0;
    end else begin
      ev_set    <= 3'h0;
      rf_wr_en  <= 1'b0;
      rf_wr2_en <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            if (undef) begin
              ev_set[`S_UNDEF] <= 1'b1;
            end else if (nop) begin
              ev_set[`S_NOP] <= 1'b1;
            end else begin
              mem_req_valid      <= 1'b1;
              mem_acquire        <= acquire;
              mem_release        <= release_ord;
              mem_tag_checked    <= tag_checked;
              mem_sp_align_check <= !tag_checked;
              mem_addr           <= tag_checked ? rf_rd_c_data : sp_value;
              mem_width          <= width_bits;
              width_reg          <= width_bits;
              dest_reg           <= dest_write;
              unk_reg            <= rt_unknown;
              is_pair_reg        <= is_pair;
              if (is_pair) begin
                mem_op      <= `MOP_BIC;
                mem_operand <= big_end_reg ? {rf_rd_a_data, rf_rd_b_data}
                                           : {rf_rd_b_data, rf_rd_a_data};
              end else begin
                mem_op      <= `MOP_XOR;
                mem_operand <= {64'h0, zext(rf_rd_b_data, width_bits)};
              end
              state_reg <= ST_REQ;
            end
          end
        end
        ST_REQ: begin
          if (mem_req_ready) begin
            mem_req_valid <= 1'b0;
            state_reg     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_resp_valid) begin
            result_reg <= unk_reg ? 128'h0 : mem_resp_data;
            state_reg  <= ST_WB;
          end
        end
        ST_WB: begin
          rf_wr_idx        <= tgt;
          rf_wr2_idx       <= src;
          ev_set[`S_DONE]  <= 1'b1;
          state_reg        <= ST_IDLE;
          if (is_pair_reg) begin
            rf_wr_en    <= 1'b1;
            rf_wr2_en   <= 1'b1;
            rf_wr_data  <= big_end_reg ? result_reg[127:64] : result_reg[63:0];
            rf_wr2_data <= big_end_reg ? result_reg[63:0] : result_reg[127:64];
          end else begin
            rf_wr_en   <= dest_reg;
            rf_wr_data <= zext(result_reg[63:0], width_reg);
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // atomic_xor_clear_rmw

// *** tb/mem_atomic_model.sv ***
`timescale 1ns/1ns
module mem_atomic_model #(parameter [127:0] INIT = 128'h0) (
  input  wire         clk,
  input  wire         rst,
  input  wire         slow,
  input  wire         mem_req_valid,
  output reg          mem_req_ready,
  input  wire [63:0]  mem_addr,
  input  wire [127:0] mem_operand,
  input  wire [7:0]   mem_width,
  input  wire [1:0]   mem_op,
  input  wire [2:0]   attr,
  output reg          mem_resp_valid,
  output wire [127:0] mem_resp_data
);
  reg [127:0] mem, old, cap_opnd;
  reg [63:0]  cap_addr;
  reg [12:0]  cap;
  reg [1:0]   cnt;
  reg         pend;
  integer     n_req;
  wire [127:0] wmask = mem_width[7] ? ~128'h0 : ((128'h1 << mem_width) - 128'h1);
  // Idle response bus shows garbage
  assign mem_resp_data = mem_resp_valid ? old : ~old;
  // One indivisible update per accepted request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem <= INIT;
      old <= 128'h0;
      {mem_req_ready, mem_resp_valid, pend, cnt} <= 5'h0;
      n_req <= 0;
    end else begin
      mem_req_ready <= 1'b0;
      mem_resp_valid <= 1'b0;
      if (mem_req_valid && mem_req_ready) begin
        {cap_addr, cap_opnd, cap} <= {mem_addr, mem_operand, attr, mem_width, mem_op}; // [17]
        n_req <= n_req + 1;
        old <= mem;
        pend <= 1'b1;
        cnt <= 2'h0;
        mem <= (mem_op == 2'h2) ? (mem & ~mem_operand) : (mem ^ (mem_operand & wmask)); // [09][13][16]
      end else if (pend) begin
        cnt <= cnt + 2'h1;
        if (cnt == {slow, 1'b0}) begin
          mem_resp_valid <= 1'b1; // [09]
          pend <= 1'b0;
        end
      end else if (mem_req_valid) begin
        cnt <= cnt + 2'h1;
        if (cnt == {slow, slow}) mem_req_ready <= 1'b1;
      end
    end
  end
endmodule // mem_atomic_model

// *** tb/rmw_monitor.sv ***
`timescale 1ns/1ns
module rmw_monitor (
  input wire         clk,
  input wire         rst,
  input wire         mem_req_valid,
  input wire         mem_req_ready,
  input wire [63:0]  mem_addr,
  input wire [127:0] mem_operand,
  input wire [7:0]   mem_width,
  input wire [1:0]   mem_op,
  input wire         mem_acquire,
  input wire         mem_tag_checked,
  input wire         mem_sp_align_check,
  input wire         mem_resp_valid,
  input wire [4:0]   rf_rd_a_idx,
  input wire [4:0]   rf_rd_b_idx,
  input wire [4:0]   rf_rd_c_idx,
  input wire [63:0]  sp_value,
  input wire         rf_wr_en,
  input wire [4:0]   rf_wr_idx,
  input wire         rf_wr2_en,
  input wire [4:0]   rf_wr2_idx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Request fields and handshake
  chk_req_hold: assert property (mem_req_valid && !mem_req_ready |=>
    mem_req_valid && $stable(mem_operand) && $stable(mem_addr)) else $error("request changed before accept");
  chk_one_outstanding: assert property (mem_req_valid && mem_req_ready |=> !mem_req_valid [*3])
    else $error("second request too soon");
  chk_acq_zero_dest: assert property (mem_req_valid && mem_op == 2'h1 && rf_rd_a_idx == 5'h1f |-> !mem_acquire)
    else $error("acquire with zero target");
  chk_tag_base: assert property (mem_req_valid |-> mem_tag_checked == (rf_rd_c_idx != 5'h1f))
    else $error("tag check flag wrong");
  chk_sp_base: assert property (mem_req_valid && rf_rd_c_idx == 5'h1f |-> mem_sp_align_check && mem_addr == sp_value)
    else $error("stack base not used");
  chk_pair_shape: assert property (mem_req_valid && mem_op == 2'h2 |->
    mem_width == 8'h80 && rf_rd_a_idx != 5'h1f && rf_rd_b_idx != 5'h1f) else $error("bad pair request");
  chk_xor_width: assert property (mem_req_valid && mem_op == 2'h1 |-> mem_width inside {8'h08, 8'h20, 8'h40})
    else $error("bad xor width");
  // Register write-back
  chk_zero_dest: assert property (rf_wr_en |-> rf_wr_idx != 5'h1f)
    else $error("write to zero register");
  chk_wb_time: assert property ($rose(rf_wr_en) |-> $past(mem_resp_valid, 2))
    else $error("write-back not after response");
  chk_pair_both: assert property (rf_wr2_en |-> rf_wr_en && rf_wr2_idx == rf_rd_b_idx)
    else $error("pair write incomplete");
  cover property (mem_req_valid && mem_req_ready && mem_op == 2'h2);
  cover property (mem_req_valid && mem_sp_align_check);
  cover property (rf_wr2_en);
endmodule // rmw_monitor

bind atomic_xor_clear_rmw rmw_monitor u_rmw_monitor (.clk, .rst, .mem_req_valid, .mem_req_ready, .mem_addr,
  .mem_operand, .mem_width, .mem_op, .mem_acquire, .mem_tag_checked, .mem_sp_align_check, .mem_resp_valid,
  .rf_rd_a_idx, .rf_rd_b_idx, .rf_rd_c_idx, .sp_value, .rf_wr_en, .rf_wr_idx, .rf_wr2_en, .rf_wr2_idx);

// *** tb/test_atomic_xor_clear_rmw.sv ***
`timescale 1ns/1ns
module test_atomic_xor_clear_rmw;
  reg          clk = 0, rst = 1, slow = 0, avs_read = 0, avs_write = 0;
  reg  [2:0]   avs_address = 3'h0;
  reg  [31:0]  avs_writedata = 32'h0, r;
  wire [31:0]  avs_readdata;
  wire         avs_waitrequest, irq, wen, wen2, rqv, rqr, acq, rel, tag, spc, rsv;
  wire [4:0]   ia, ib, ic;
  wire [63:0]  wd, wd2, addr;
  wire [127:0] opnd, rdat;
  wire [7:0]   wid;
  wire [1:0]   op;
  reg  [127:0] em, old;
  reg  [63:0]  w1, w2;
  integer      num_errors = 0, num_checks = 0, k, nw = 0, n0;
  function [63:0] rv(input [4:0] i); rv = {8{3'h5, i}}; endfunction
  function [31:0] xi(input [1:0] z, input a, l, input [4:0] s, n, t); xi = {z, 6'h38, a, l, 1'b1, s, 6'h08, n, t};
  endfunction
  function [31:0] pi(input a, l, input [4:0] s, n, t); pi = {8'h19, a, l, 1'b1, s, 6'h04, n, t}; endfunction
  initial forever #50 clk = ~clk;
  atomic_xor_clear_rmw u_atomic_xor_clear_rmw (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .rf_rd_a_idx(ia), .rf_rd_b_idx(ib), .rf_rd_c_idx(ic),
    .rf_rd_a_data(rv(ia)), .rf_rd_b_data(rv(ib)), .rf_rd_c_data(rv(ic)), .sp_value(64'h1000), .rf_wr_en(wen),
    .rf_wr_idx(), .rf_wr_data(wd), .rf_wr2_en(wen2), .rf_wr2_idx(), .rf_wr2_data(wd2), .mem_req_valid(rqv),
    .mem_req_ready(rqr), .mem_addr(addr), .mem_operand(opnd), .mem_width(wid), .mem_op(op), .mem_acquire(acq),
    .mem_release(rel), .mem_tag_checked(tag), .mem_sp_align_check(spc), .mem_resp_valid(rsv), .mem_resp_data(rdat));
  mem_atomic_model #(.INIT(128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0)) mm (.clk(clk), .rst(rst), .slow(slow),
    .mem_req_valid(rqv), .mem_req_ready(rqr), .mem_addr(addr), .mem_operand(opnd), .mem_width(wid), .mem_op(op),
    .attr({acq, rel, tag}), .mem_resp_valid(rsv), .mem_resp_data(rdat));
  // Capture register write-back
  always @(posedge clk) begin
    if (wen) begin w1 <= wd; nw <= nw + 1; end
    if (wen2) w2 <= wd2;
  end
  task chk(input [127:0] s, e); begin
    num_checks = num_checks + 1;
    if (s !== e) begin num_errors = num_errors + 1; $display("Error %0t: saw %h want %h", $time, s, e); end
  end endtask
  task acc(input [2:0] a, input wt, input [31:0] d); begin
    @(posedge clk);
    avs_address <= a; avs_writedata <= d; avs_write <= wt; avs_read <= !wt;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    r = avs_readdata;
    avs_write <= 1'b0; avs_read <= 1'b0;
  end endtask
  task go(input [31:0] i, c, s); begin
    acc(0, 1, i); acc(1, 1, c | 32'h1); k = 0;
    while (irq !== 1'b1 && k < 300) begin @(posedge clk); k = k + 1; end
    acc(2, 0, 0); chk(r, s);
    @(posedge clk); chk(irq, 0);
  end endtask
  task at(input [10:0] e, input [1:0] o); chk(mm.cap, {e, o}); endtask
  task summarize; begin
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  initial begin #3000000; num_errors = num_errors + 1; summarize; end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0; em = mm.INIT;
    acc(1, 0, 0); chk(r, 2); acc(7, 0, 0); chk(r, 0); acc(3, 1, 7);
    old = em; em = em ^ (rv(4) & 64'hffffffff);
    go(xi(2, 1, 0, 4, 5, 3), 2, 1); chk(mm.mem, em); chk(w1, old[31:0]);
    at({3'h5, 8'd32}, 2'h1); chk(mm.cap_addr, rv(5));
    slow = 1; old = em; em = em ^ rv(7); n0 = nw;
    go(xi(3, 1, 1, 7, 9, 31), 2, 1); chk(nw, n0); chk(mm.mem, em);
    at({3'h3, 8'd64}, 2'h1);
    slow = 0; old = em; em = em ^ (rv(2) & 64'hff);
    go(xi(0, 0, 0, 2, 31, 1), 2, 1); chk(mm.mem, em); chk(w1, old[7:0]);
    at({3'h0, 8'd8}, 2'h1); chk(mm.cap_addr, 64'h1000);
    old = em; em = em & ~{rv(6), rv(2)};
    go(pi(1, 0, 6, 5, 2), 2, 1); chk(mm.cap_opnd, {rv(6), rv(2)}); chk({w2, w1}, old);
    chk(mm.mem, em); chk(mm.cap[1:0], 2); at({3'h5, 8'd128}, 2'h2);
    old = em; em = em & ~{rv(2), rv(6)}; slow = 1;
    go(pi(0, 1, 6, 5, 2), 6, 1); chk(mm.cap_opnd, {rv(2), rv(6)}); chk({w1, w2}, old);
    at({3'h3, 8'd128}, 2'h2); n0 = mm.n_req;
    go(pi(0, 0, 6, 5, 31), 2, 2); go(pi(0, 0, 31, 5, 2), 2, 2);
    go(pi(0, 0, 6, 5, 2), 0, 2);
    go(pi(0, 0, 3, 5, 3), 32'ha, 2); go(pi(0, 0, 3, 5, 3), 32'h12, 4); chk(mm.n_req, n0);
    em = em & ~{rv(3), rv(3)};
    go(pi(0, 0, 3, 5, 3), 2, 1); chk(w1, 0); chk(mm.mem, em);
    acc(3, 1, 0); acc(0, 1, pi(0, 0, 6, 5, 31)); acc(1, 1, 3); r = 0;
    for (k = 0; k < 30 && r == 0; k = k + 1) begin chk(irq, 0); acc(2, 0, 0); end
    chk(r, 2);
    summarize;
  end
endmodule // test_atomic_xor_clear_rmw
